// ---- core/tcr_map.svh ----
`ifndef TCR_MAP_SVH
`define TCR_MAP_SVH

// ==========================================
// register offsets (byte addresses)
`define TCR_OFS_CH0 8'h00
`define TCR_OFS_CH1 8'h04
`define TCR_OFS_CH2 8'h08
`define TCR_OFS_CH3 8'h0C
`define TCR_OFS_STATUS 8'h10
`define TCR_OFS_CONFIG 8'h14
`define TCR_OFS_CTRL 8'h18

// ==========================================
// field positions
`define TCR_STS_RANGE_BIT 3
`define TCR_STS_PWRBAD_BIT 2
`define TCR_CTRL_REFRESH_BIT 0
`define TCR_CFG_DIR_BIT 3
`define TCR_CFG_CURDIS_BIT 4
`define TCR_CFG_FAHR_BIT 5
`define TCR_CFG_CJDIS_BIT 6

// ==========================================
// reset values
`define TCR_CTRL_RESET 1'h1
`define TCR_DATA_RESET 16'h0000

// ==========================================
// channel codes
`define TCR_CODE_OVER 16'h7FFF
`define TCR_CODE_UNDER 16'h8000
`define TCR_CODE_NOPWR 16'h7FFE
`define TCR_CODE_DIAG 16'h0000
`define TCR_CODE_MAX 32'sh00007FFF
`define TCR_CODE_MIN 32'shFFFF8000
`define TCR_MV_TOP 32'sh00007EFF
`define TCR_MV_BOTTOM 32'shFFFF8100

// ==========================================
// scaling
`define TCR_OW_UV 32'sh00030D40
`define TCR_MV_FULL_CODE 32'sh00006C00
`define TCR_MV_FULL_UV 32'sh00013880
`define TCR_F_MUL 32'sh00000009
`define TCR_F_DIV 32'sh00000005
`define TCR_F_OFS 32'sh00000140

// ==========================================
// timing
`define TCR_CLK_HZ 20000000
`define TCR_UPDATE_MS 405
`define TCR_BLINK_MS 250
`define TCR_SETTLE_LAST 2'h3

`endif

// ---- core/tcr_pkg.sv ----
package tcr_pkg;

	typedef enum logic [1:0]
	{
		TCR_ST_SETTLE = 2'h0,
		TCR_ST_LATCH = 2'h1,
		TCR_ST_RUN = 2'h3
	} tcr_state_t;

	typedef enum logic [2:0]
	{
		TCR_TC_J = 3'h0,
		TCR_TC_K = 3'h1,
		TCR_TC_T = 3'h2,
		TCR_TC_E = 3'h3,
		TCR_TC_R = 3'h4,
		TCR_TC_S = 3'h5,
		TCR_TC_N = 3'h6,
		TCR_TC_MV = 3'h7
	} tcr_sensor_t;

endpackage

// ---- core/tcr_chan_fmt.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcr_map.svh"

module tcr_chan_fmt
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sampleValid,
	input wire tcr_pkg::tcr_sensor_t sensorType,
	input wire logic owDirDown,
	input wire logic fahrenheit,
	input wire logic cjDisable,
	input wire logic userPowerOk,
	input wire logic diagError,
	input wire logic [19:0] inMicrovolt,
	input wire logic [15:0] inTenths,
	input wire logic [15:0] cjTenths,
	input wire logic linOver,
	input wire logic linUnder,
	output logic [15:0] value,
	output logic rangeErr
);
	logic [15:0] valueReg, valueNext;
	logic rangeReg, rangeNext;
	logic signed [31:0] uv, scaled, tempC, temp;
	logic openWire, cjOn, isMv;

	// ==========================================
	// conversion and error coding
	always_comb
	begin
		valueNext = valueReg;
		rangeNext = rangeReg;
		uv = $signed({{12{inMicrovolt[19]}}, inMicrovolt});
		isMv = (sensorType == tcr_pkg::TCR_TC_MV);
		openWire = (uv > `TCR_OW_UV) || (uv < -`TCR_OW_UV);
		// linear millivolt scaling
		// product taken at 64 bits: inputs near the open-wire limit overflow 32 bits
		scaled = 32'((64'(uv) * 64'(`TCR_MV_FULL_CODE)) / 64'(`TCR_MV_FULL_UV));
		cjOn = !cjDisable && !isMv;
		// linearizer output is taken as compensated by adding the junction temperature
		tempC = $signed({{16{inTenths[15]}}, inTenths}) + (cjOn ? $signed({{16{cjTenths[15]}}, cjTenths}) : 32'sh0);
		temp = fahrenheit ? (tempC * `TCR_F_MUL) / `TCR_F_DIV + `TCR_F_OFS : tempC;
		if (sampleValid)
		begin
			rangeNext = 1'b0;
			if (diagError)
				valueNext = `TCR_CODE_DIAG;
			else if (!userPowerOk)
				valueNext = `TCR_CODE_NOPWR;
			else if (openWire)
			begin
				valueNext = owDirDown ? `TCR_CODE_UNDER : `TCR_CODE_OVER;
				rangeNext = 1'b1;
			end
			else if (isMv)
			begin
				if (scaled > `TCR_MV_TOP)
				begin
					valueNext = `TCR_CODE_OVER;
					rangeNext = 1'b1;
				end
				else if (scaled < `TCR_MV_BOTTOM)
				begin
					valueNext = `TCR_CODE_UNDER;
					rangeNext = 1'b1;
				end
				else
					valueNext = scaled[15:0];
			end
			else if (linOver || temp > `TCR_CODE_MAX)
			begin
				valueNext = `TCR_CODE_OVER;
				rangeNext = 1'b1;
			end
			else if (linUnder || temp < `TCR_CODE_MIN)
			begin
				valueNext = `TCR_CODE_UNDER;
				rangeNext = 1'b1;
			end
			else
				valueNext = temp[15:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			valueReg <= `TCR_DATA_RESET;
			rangeReg <= 1'b0;
		end
		else
		begin
			valueReg <= valueNext;
			rangeReg <= rangeNext;
		end
	end

	assign value = valueReg;
	assign rangeErr = rangeReg;

	// ==========================================
	// checks
	default clocking fcb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	ow_dir_a: assert property (sampleValid && !diagError && userPowerOk && openWire |=> rangeReg && valueReg == (owDirDown ? 16'h8000 : 16'h7FFF)) else $error("open wire code wrong");
	mv_scale_a: assert property (sampleValid && isMv && !openWire && !diagError && userPowerOk && uv == 32'sh00013880 |=> valueReg == 16'h6C00) else $error("80 mV scale wrong");
	nopwr_code_a: assert property (sampleValid && !diagError && !userPowerOk |=> valueReg == 16'h7FFE && !rangeReg) else $error("no power code wrong");
	diag_code_a: assert property (sampleValid && diagError |=> valueReg == 16'h0000) else $error("diag code wrong");
endmodule // tcr_chan_fmt

`default_nettype wire

// ---- core/tcr_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "tcr_map.svh"

// How it works
// - three-bit switch selects sensor type
// - switches latched once after reset
// - open wire goes up or down
// - compensation added when switch low
// - no compensation in millivolt range
// - range fault: extreme code, blink
// - no 24 V: 32766, power bad
// - diagnostic: zero data, fault steady
// - healthy: data, supply led on
// - range flag at status bit 3
// - power bad at status bit 2
// - signed 16-bit words in tenths
// - 80 mV maps to 27648
// - refresh every 405 ms after read
// - unread data stays until read
// - beyond valid range: 32767 or -32768
module tcr_top
#(
	parameter int UPDATE_CYCLES = `TCR_UPDATE_MS * (`TCR_CLK_HZ / 1000),
	parameter int BLINK_CYCLES = `TCR_BLINK_MS * (`TCR_CLK_HZ / 1000)
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] sensorTypeSwitch,
	input wire logic openWireDirectionSwitch,
	input wire logic openWireCurrentEnableSwitch,
	input wire logic temperatureScaleSwitch,
	input wire logic coldJunctionSwitch,
	input wire logic userPowerOkPin,
	input wire logic diagErrorIn,
	input wire logic sampleValid,
	input wire logic [3:0][19:0] chMicrovolt,
	input wire logic [3:0][15:0] chTenths,
	input wire logic [15:0] cjTenths,
	input wire logic [3:0] chLinOver,
	input wire logic [3:0] chLinUnder,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	output logic currentSourceOn,
	output logic faultIndicatorLed,
	output logic supplyLed,
	output logic moduleConfigError,
	output logic [7:0] moduleErrorStatusByte,
	output logic updateStrobe
);
	// ==========================================
	// pin synchronisers
	logic [7:0] pinMeta, pinSync;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pinMeta <= 8'h00;
			pinSync <= 8'h00;
		end
		else
		begin
			pinMeta <= {userPowerOkPin, coldJunctionSwitch, temperatureScaleSwitch, openWireCurrentEnableSwitch,
				openWireDirectionSwitch, sensorTypeSwitch};
			pinSync <= pinMeta;
		end
	end

	logic userPowerOk;
	assign userPowerOk = pinSync[7];

	// ==========================================
	// configuration capture
	tcr_pkg::tcr_state_t stateReg, stateNext;
	logic [1:0] settleReg, settleNext;
	logic [6:0] cfgReg, cfgNext;
	logic running;

	always_comb
	begin
		stateNext = stateReg;
		settleNext = settleReg;
		cfgNext = cfgReg;
		case (stateReg)
			tcr_pkg::TCR_ST_SETTLE:
			begin
				settleNext = settleReg + 2'h1;
				if (settleReg == `TCR_SETTLE_LAST)
					stateNext = tcr_pkg::TCR_ST_LATCH;
			end
			tcr_pkg::TCR_ST_LATCH:
			begin
				cfgNext = pinSync[6:0];
				stateNext = tcr_pkg::TCR_ST_RUN;
			end
			tcr_pkg::TCR_ST_RUN:
				stateNext = tcr_pkg::TCR_ST_RUN;
			default:
				stateNext = tcr_pkg::TCR_ST_SETTLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stateReg <= tcr_pkg::TCR_ST_SETTLE;
			settleReg <= 2'h0;
			cfgReg <= 7'h00;
		end
		else
		begin
			stateReg <= stateNext;
			settleReg <= settleNext;
			cfgReg <= cfgNext;
		end
	end

	assign running = (stateReg == tcr_pkg::TCR_ST_RUN);

	// ==========================================
	// channel formatters
	logic [3:0][15:0] fmtValue;
	logic [3:0] fmtRange;
	logic fmtValid;
	tcr_pkg::tcr_sensor_t cfgType;

	assign fmtValid = sampleValid && running;
	assign cfgType = tcr_pkg::tcr_sensor_t'(cfgReg[2:0]);

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++)
		begin : g_ch
			tcr_chan_fmt u_fmt
			(
				.clk(clk),
				.rst_n(rst_n),
				.sampleValid(fmtValid),
				.sensorType(cfgType),
				.owDirDown(cfgReg[`TCR_CFG_DIR_BIT]),
				.fahrenheit(cfgReg[`TCR_CFG_FAHR_BIT]),
				.cjDisable(cfgReg[`TCR_CFG_CJDIS_BIT]),
				.userPowerOk(userPowerOk),
				.diagError(diagErrorIn),
				.inMicrovolt(chMicrovolt[ch]),
				.inTenths(chTenths[ch]),
				.cjTenths(cjTenths),
				.linOver(chLinOver[ch]),
				.linUnder(chLinUnder[ch]),
				.value(fmtValue[ch]),
				.rangeErr(fmtRange[ch])
			);
		end
	endgenerate

	// ==========================================
	// update timing and publishing
	logic [22:0] updCntReg, updCntNext;
	logic [22:0] blinkCntReg, blinkCntNext;
	logic blinkReg, blinkNext;
	logic [3:0][15:0] pubDataReg, pubDataNext;
	logic [3:0] pubRangeReg, pubRangeNext;
	logic readSeenReg, readSeenNext;
	logic refreshEnReg, refreshEnNext;
	logic updStrobeReg, updStrobeNext;
	logic tick, publish, chanRead;

	assign tick = (updCntReg == 23'(UPDATE_CYCLES - 1));
	assign chanRead = regRd && (regAddr == `TCR_OFS_CH0 || regAddr == `TCR_OFS_CH1 ||
		regAddr == `TCR_OFS_CH2 || regAddr == `TCR_OFS_CH3);
	assign publish = tick && readSeenReg && refreshEnReg && running;

	always_comb
	begin
		updCntNext = tick ? 23'h000000 : updCntReg + 23'h000001;
		blinkCntNext = blinkCntReg + 23'h000001;
		blinkNext = blinkReg;
		if (blinkCntReg == 23'(BLINK_CYCLES - 1))
		begin
			blinkCntNext = 23'h000000;
			blinkNext = !blinkReg;
		end
		pubDataNext = pubDataReg;
		pubRangeNext = pubRangeReg;
		if (publish)
		begin
			pubDataNext = fmtValue;
			pubRangeNext = fmtRange;
		end
		// a read landing on the publish cycle keeps the flag set
		readSeenNext = chanRead ? 1'b1 : (publish ? 1'b0 : readSeenReg);
		refreshEnNext = refreshEnReg;
		if (regWr && regAddr == `TCR_OFS_CTRL)
			refreshEnNext = regWdata[`TCR_CTRL_REFRESH_BIT];
		updStrobeNext = publish;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			updCntReg <= 23'h000000;
			blinkCntReg <= 23'h000000;
			blinkReg <= 1'b0;
			pubDataReg <= {4{`TCR_DATA_RESET}};
			pubRangeReg <= 4'h0;
			readSeenReg <= 1'b1;
			refreshEnReg <= `TCR_CTRL_RESET;
			updStrobeReg <= 1'b0;
		end
		else
		begin
			updCntReg <= updCntNext;
			blinkCntReg <= blinkCntNext;
			blinkReg <= blinkNext;
			pubDataReg <= pubDataNext;
			pubRangeReg <= pubRangeNext;
			readSeenReg <= readSeenNext;
			refreshEnReg <= refreshEnNext;
			updStrobeReg <= updStrobeNext;
		end
	end

	// ==========================================
	// indicators and status
	logic faultReg, faultNext, supplyReg, supplyNext, cfgErrReg, cfgErrNext, curSrcReg, curSrcNext;
	logic [7:0] statusReg, statusNext;
	logic rangeAny;

	assign rangeAny = |pubRangeReg;

	always_comb
	begin
		statusNext = 8'h00;
		curSrcNext = running && !cfgReg[`TCR_CFG_CURDIS_BIT];
		cfgErrNext = 1'b0;
		if (diagErrorIn)
		begin
			faultNext = 1'b1;
			supplyNext = 1'b0;
			cfgErrNext = 1'b1;
			statusNext[`TCR_STS_PWRBAD_BIT] = !userPowerOk;
		end
		else if (!userPowerOk)
		begin
			faultNext = 1'b0;
			supplyNext = 1'b0;
			statusNext[`TCR_STS_PWRBAD_BIT] = 1'b1;
		end
		else if (rangeAny)
		begin
			faultNext = blinkReg;
			supplyNext = 1'b1;
			statusNext[`TCR_STS_RANGE_BIT] = 1'b1;
		end
		else
		begin
			faultNext = 1'b0;
			supplyNext = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			faultReg <= 1'b0;
			supplyReg <= 1'b0;
			cfgErrReg <= 1'b0;
			curSrcReg <= 1'b0;
			statusReg <= 8'h00;
		end
		else
		begin
			faultReg <= faultNext;
			supplyReg <= supplyNext;
			cfgErrReg <= cfgErrNext;
			curSrcReg <= curSrcNext;
			statusReg <= statusNext;
		end
	end

	// ==========================================
	// register read port
	logic [31:0] rdataReg, rdataNext;

	always_comb
	begin
		rdataNext = 32'h00000000;
		if (regRd)
		begin
			case (regAddr)
				`TCR_OFS_CH0: rdataNext = {16'h0000, pubDataReg[0]};
				`TCR_OFS_CH1: rdataNext = {16'h0000, pubDataReg[1]};
				`TCR_OFS_CH2: rdataNext = {16'h0000, pubDataReg[2]};
				`TCR_OFS_CH3: rdataNext = {16'h0000, pubDataReg[3]};
				`TCR_OFS_STATUS: rdataNext = {24'h000000, statusReg};
				`TCR_OFS_CONFIG: rdataNext = {25'h0000000, cfgReg};
				`TCR_OFS_CTRL: rdataNext = {31'h00000000, refreshEnReg};
				default: rdataNext = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdataReg <= 32'h00000000;
		else
			rdataReg <= rdataNext;
	end

	assign regRdata = rdataReg;
	assign currentSourceOn = curSrcReg;
	assign faultIndicatorLed = faultReg;
	assign supplyLed = supplyReg;
	assign moduleConfigError = cfgErrReg;
	assign moduleErrorStatusByte = statusReg;
	assign updateStrobe = updStrobeReg;

	// ==========================================
	// checks
	default clocking tcb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	cfg_frozen_a: assert property (running |=> $stable(cfgReg)) else $error("config moved while running");
	cur_src_a: assert property (running ##1 running |-> currentSourceOn == !cfgReg[4]) else $error("current source wrong");
	range_blink_a: assert property (!diagErrorIn && userPowerOk && rangeAny |=> moduleErrorStatusByte[3] && supplyLed && faultIndicatorLed == $past(blinkReg)) else $error("range indication wrong");
	pwr_bad_a: assert property (!diagErrorIn && !userPowerOk |=> moduleErrorStatusByte[2] && !moduleErrorStatusByte[3] && !faultIndicatorLed && !supplyLed) else $error("power bad indication wrong");
	diag_led_a: assert property (diagErrorIn |=> faultIndicatorLed && !supplyLed && moduleConfigError && !moduleErrorStatusByte[3]) else $error("diag indication wrong");
	healthy_a: assert property (!diagErrorIn && userPowerOk && !rangeAny |=> !faultIndicatorLed && supplyLed && moduleErrorStatusByte[3:2] == 2'h0) else $error("healthy indication wrong");
	status_bits_a: assert property (moduleErrorStatusByte[7:4] == 4'h0 && moduleErrorStatusByte[1:0] == 2'h0) else $error("stray status bits");
	refresh_copy_a: assert property (publish |=> pubDataReg == $past(fmtValue) ##0 updateStrobe) else $error("refresh not copied");
	period_a: assert property (tick |=> !tick [*8]) else $error("update period too short");
	stale_hold_a: assert property (tick && !readSeenReg |=> $stable(pubDataReg) && !updateStrobe) else $error("unread data replaced");
	read_kept_a: assert property (chanRead |=> readSeenReg) else $error("read lost");

	refresh_c: cover property (publish);
	stale_c: cover property (tick && !readSeenReg && running);
	range_c: cover property (rangeAny && faultIndicatorLed);
	nopwr_c: cover property (moduleErrorStatusByte[2]);
endmodule // tcr_top

`default_nettype wire

// ---- test/tcr_cpu_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================
// controller side of the register port
module tcr_cpu_model
(
	input wire logic clk,
	output logic [7:0] regAddr,
	output logic [31:0] regWdata,
	output logic regWr,
	output logic regRd,
	input wire logic [31:0] regRdata
);
	initial
	begin
		regAddr = 8'h00;
		regWdata = 32'h00000000;
		regWr = 1'b0;
		regRd = 1'b0;
	end

	// reading a channel word re-arms refresh
	// the bench's publish task calls this on channel 0 before waiting for each refresh
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
endmodule // tcr_cpu_model

`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end

// ==========================================
// bench for the channel reporting block
module tb_top;
	logic clk, rst_n, sampleValid, userPowerOkPin, diagErrorIn, regWr, regRd;
	logic openWireDirectionSwitch, openWireCurrentEnableSwitch, temperatureScaleSwitch, coldJunctionSwitch;
	logic currentSourceOn, faultIndicatorLed, supplyLed, moduleConfigError, updateStrobe;
	logic [2:0] sensorTypeSwitch;
	logic [3:0][19:0] chMicrovolt;
	logic [3:0][15:0] chTenths;
	logic [15:0] cjTenths;
	logic [3:0] chLinOver, chLinUnder;
	logic [7:0] regAddr, moduleErrorStatusByte, n;
	logic [31:0] regWdata, regRdata, d;
	int mismatches = 0;
	int num_checks = 0;
	localparam int UPD = 20;

	always #25 clk = ~clk;

	tcr_top #(.UPDATE_CYCLES(UPD), .BLINK_CYCLES(4)) i_tcr_top (.clk, .rst_n, .sensorTypeSwitch,
		.openWireDirectionSwitch, .openWireCurrentEnableSwitch, .temperatureScaleSwitch, .coldJunctionSwitch,
		.userPowerOkPin, .diagErrorIn, .sampleValid, .chMicrovolt, .chTenths, .cjTenths, .chLinOver, .chLinUnder,
		.regAddr, .regWdata, .regWr, .regRd, .regRdata, .currentSourceOn, .faultIndicatorLed, .supplyLed,
		.moduleConfigError, .moduleErrorStatusByte, .updateStrobe);

	tcr_cpu_model i_tcr_cpu_model (.clk, .regAddr, .regWdata, .regWr, .regRd, .regRdata);

	task stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// switches are only taken after reset, so each setup needs its own reset
	task boot(input logic [2:0] t, input logic [3:0] sw);
		@(posedge clk);
		rst_n <= 1'b0;
		{coldJunctionSwitch, temperatureScaleSwitch, openWireCurrentEnableSwitch, openWireDirectionSwitch} <= sw;
		sensorTypeSwitch <= t;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
	endtask

	// the power pin is synchronised, so let it settle before sampling
	task feed(input logic [3:0][19:0] uv, input logic [3:0][15:0] t, input logic [15:0] cj, input logic [3:0] un);
		@(posedge clk);
		chMicrovolt <= uv;
		chTenths <= t;
		cjTenths <= cj;
		chLinUnder <= un;
		repeat (3) @(posedge clk);
		sampleValid <= 1'b1;
		@(posedge clk);
		sampleValid <= 1'b0;
	endtask

	task publish();
		int k;
		i_tcr_cpu_model.rd(8'h00, d);
		for (k = 0; k < 3 * UPD && updateStrobe !== 1'b1; k++)
		begin
			@(posedge clk);
			#1;
		end
		`CHK(updateStrobe, 1'b1)
	endtask

	task chk4(input logic [3:0][15:0] e);
		for (int i = 0; i < 4; i++)
		begin
			i_tcr_cpu_model.rd(8'(4 * i), d);
			`CHK(d, {16'h0000, e[i]})
		end
	endtask

	task chk_ind(input logic [1:0] sc, input logic [7:0] s);
		repeat (2) @(posedge clk);
		#1;
		`CHK({supplyLed, currentSourceOn}, sc)
		`CHK(moduleErrorStatusByte, s)
	endtask

	task blink();
		n = 8'h00;
		repeat (16)
		begin
			@(posedge clk);
			#1;
			n = n + {7'h00, faultIndicatorLed};
		end
		`CHK(n, 8'h08)
	endtask

	task quiet();
		n = 8'h00;
		repeat (3 * UPD)
		begin
			@(posedge clk);
			#1;
			n = n + {7'h00, updateStrobe};
		end
	endtask

	task t_types();
		for (int i = 0; i < 8; i++)
		begin
			boot(3'(i), 4'hA);
			i_tcr_cpu_model.rd(8'h14, d);
			`CHK(d, {25'h0000000, 4'hA, 3'(i)})
		end
		$display("test types done");
	endtask

	task t_celsius();
		boot(3'h0, 4'h0);
		feed(80'h0, {16'h32C8, 16'h0000, 16'hFE0C, 16'h03EA}, 16'h0019, 4'h0);
		publish();
		chk4({16'h32E1, 16'h0019, 16'hFE25, 16'h0403});
		chk_ind(2'h3, 8'h00);
		`CHK(faultIndicatorLed, 1'b0)
		@(posedge clk);
		temperatureScaleSwitch <= 1'b1;
		coldJunctionSwitch <= 1'b1;
		feed(80'h0, {16'h32C8, 16'h0000, 16'hFE0C, 16'h03EA}, 16'h0019, 4'h0);
		publish();
		chk4({16'h32E1, 16'h0019, 16'hFE25, 16'h0403});
		$display("test celsius done");
	endtask

	task t_fahr();
		boot(3'h1, 4'hE);
		feed({20'h493E0, 60'h0}, {16'h0000, 16'h0000, 16'hFE70, 16'h03E8}, 16'h0032, 4'h4);
		publish();
		chk4({16'h7FFF, 16'h8000, 16'hFE70, 16'h0848});
		chk_ind(2'h2, 8'h08);
		blink();
		$display("test fahrenheit done");
	endtask

	task t_mv();
		boot(3'h7, 4'h1);
		feed({20'hC2F70, 20'h16F94, 20'hF15A0, 20'h13880}, 64'h0, 16'h0032, 4'h0);
		publish();
		chk4({16'h8000, 16'h7FFF, 16'hAF00, 16'h6C00});
		chk_ind(2'h3, 8'h08);
		blink();
		$display("test millivolt done");
	endtask

	task t_power();
		boot(3'h0, 4'h0);
		userPowerOkPin <= 1'b0;
		feed(80'h0, {4{16'h0064}}, 16'h0000, 4'h0);
		publish();
		chk4({4{16'h7FFE}});
		chk_ind(2'h1, 8'h04);
		`CHK(faultIndicatorLed, 1'b0)
		userPowerOkPin <= 1'b1;
		diagErrorIn <= 1'b1;
		feed(80'h0, {4{16'h0064}}, 16'h0000, 4'h0);
		publish();
		chk4(64'h0);
		chk_ind(2'h1, 8'h00);
		`CHK({faultIndicatorLed, moduleConfigError}, 2'h3)
		diagErrorIn <= 1'b0;
		$display("test power done");
	endtask

	task t_stale();
		boot(3'h0, 4'h0);
		i_tcr_cpu_model.rd(8'h18, d);
		`CHK(d, 32'h00000001)
		feed(80'h0, {4{16'h0064}}, 16'h0000, 4'h0);
		publish();
		i_tcr_cpu_model.rd(8'h00, d);
		n = 8'h00;
		while (updateStrobe !== 1'b1 && n < 8'h64)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK(n, 8'(UPD - 2))
		feed(80'h0, {4{16'h00C8}}, 16'h0000, 4'h0);
		quiet();
		`CHK(n, 8'h00)
		i_tcr_cpu_model.rd(8'h00, d);
		`CHK(d, 32'h00000064)
		publish();
		i_tcr_cpu_model.rd(8'h00, d);
		`CHK(d, 32'h000000C8)
		i_tcr_cpu_model.wr(8'h18, 32'h00000000);
		feed(80'h0, {4{16'h012C}}, 16'h0000, 4'h0);
		quiet();
		`CHK(n, 8'h00)
		i_tcr_cpu_model.rd(8'h40, d);
		`CHK(d, 32'h00000000)
		$display("test stale done");
	endtask

	// the whole run takes about 520 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		stop_test();
	end

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		{sampleValid, userPowerOkPin, diagErrorIn} = 3'h2;
		{openWireDirectionSwitch, openWireCurrentEnableSwitch, temperatureScaleSwitch, coldJunctionSwitch} = 4'h0;
		sensorTypeSwitch = 3'h0;
		chMicrovolt = 80'h0;
		chTenths = 64'h0;
		cjTenths = 16'h0000;
		{chLinOver, chLinUnder} = 8'h00;
		t_types();
		t_celsius();
		t_fahr();
		t_mv();
		t_power();
		t_stale();
		stop_test();
	end
endmodule // tb_top

`default_nettype wire
